/* File: pkg/daq_timing_consts.vh */
// Constants for the acquisition trigger and timing control block
// Summary of operation
// - Falling external convert edge starts one conversion
// - Dedicated interval and sample counters pace, end
// - Software picks post or pre trigger, one only
// - Post, internal timing: trigger edge starts pacing
// - Post, external: trigger then convert rise enables
// - Post: later triggers ignored until new sequence
// - Pre: sample counter held until stop trigger
// - Pre: convert until count zero, max 65535
// - Pre: later triggers ignored until new sequence
// - Scan interval from counter or external line
// - Scan: scan rise opens gate, at next convert rise if external
// - Immediate mode: DAC output follows write at once
// - Delayed mode: DAC waits for low update level
// - Interrupt on each update rising edge when enabled
// - Outputs load while internal update signal high
`ifndef DAQ_TIMING_CONSTS_VH
`define DAQ_TIMING_CONSTS_VH
`define CLK_PERIOD_NS 4
`define EXT_SETUP_NS 50
`define EXT_SETUP_CYC ((`EXT_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DAC_WIDTH 12
`define CNT_WIDTH 16
`define DAC_RESET 12'h000
`define ST_IDLE 4'h1
`define ST_ARMED 4'h2
`define ST_RUN 4'h4
`define ST_DONE 4'h8
`endif

/* File: rtl/edge_sync.v */
// Two-stage synchroniser with rise and fall detection
module edge_sync (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Raw line and results
    input wire din,
    output reg level,
    output reg rise,
    output reg fall
);
    reg meta_ff;
    reg sync_ff;
    always @(posedge clk) begin
        if (srst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            level <= 1'b1;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            level <= sync_ff;
            rise <= sync_ff & ~level;
            fall <= ~sync_ff & level;
        end
    end
endmodule // edge_sync

/* File: rtl/daq_trigger_timing_control.v */
// Acquisition trigger, conversion pacing, scan gate and DAC update control
`include "daq_timing_consts.vh"
module daq_trigger_timing_control #(
    parameter CNT_W = `CNT_WIDTH,
    parameter DAC_W = `DAC_WIDTH
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // External timing lines
    input wire ext_convert_n,
    input wire ext_trigger,
    input wire scan_interval_line,
    input wire ext_dac_update_n,
    // Acquisition control
    input wire start_acq,
    input wire stop_acq,
    input wire trigger_enable,
    input wire post_trigger_mode,
    input wire pre_trigger_mode,
    input wire ext_conv_sel,
    input wire scan_enable,
    input wire ext_scan_sel,
    input wire [CNT_W-1:0] sample_interval_load,
    input wire [CNT_W-1:0] sample_count_load,
    input wire [CNT_W-1:0] scan_interval_load,
    input wire [CNT_W-1:0] scan_length,
    // DAC control
    input wire delayed_update_mode,
    input wire int_enable,
    input wire int_clear,
    input wire dac_write_strobe,
    input wire dac_sel,
    input wire [DAC_W-1:0] dac_wdata,
    // Outputs
    output reg convert_pulse,
    output reg acq_active,
    output reg acq_done,
    output reg trigger_seen,
    output reg scan_gate,
    output reg [DAC_W-1:0] dac0_out,
    output reg [DAC_W-1:0] dac1_out,
    output reg dac_output_update,
    output reg host_interrupt
);
    localparam [3:0] S_IDLE = `ST_IDLE;
    localparam [3:0] S_ARMED = `ST_ARMED;
    localparam [3:0] S_RUN = `ST_RUN;
    localparam [3:0] S_DONE = `ST_DONE;
    localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    wire conv_rise, conv_fall;
    wire trig_rise;
    wire scan_rise;
    wire upd_lvl, upd_rise;

    edge_sync u_conv (.clk(clk), .srst(srst), .din(ext_convert_n),
        .level(), .rise(conv_rise), .fall(conv_fall));
    edge_sync u_trig (.clk(clk), .srst(srst), .din(ext_trigger),
        .level(), .rise(trig_rise), .fall());
    edge_sync u_scan (.clk(clk), .srst(srst), .din(scan_interval_line),
        .level(), .rise(scan_rise), .fall());
    edge_sync u_upd (.clk(clk), .srst(srst), .din(ext_dac_update_n),
        .level(upd_lvl), .rise(upd_rise), .fall());

    reg [3:0] state_ff, nxt_state;
    reg [CNT_W-1:0] sample_interval_counter, nxt_interval;
    reg [CNT_W-1:0] sample_count_counter, nxt_count;
    reg [CNT_W-1:0] scan_interval_counter, nxt_scan_cnt;
    reg [CNT_W-1:0] scan_left_ff, nxt_scan_left;
    reg conv_en_ff, nxt_conv_en;
    reg count_run_ff, nxt_count_run;
    reg scan_tick_ff, nxt_scan_tick;
    reg scan_pend_ff, nxt_scan_pend;
    reg [DAC_W-1:0] dac0_hold_ff, dac1_hold_ff;
    reg dac0_pend_ff, dac1_pend_ff;
    reg nxt_convert, nxt_gate;

    // Only one trigger mode may steer the trigger line
    wire post_sel = post_trigger_mode & ~pre_trigger_mode;
    wire pre_sel = pre_trigger_mode & ~post_trigger_mode;
    wire trig_ok = trigger_enable & (post_sel | pre_sel);
    wire int_tick = (sample_interval_counter == ONE);
    wire scan_src = ext_scan_sel ? scan_rise : scan_tick_ff;
    wire scanning = scan_enable;
    wire conv_now;
    wire conv_time = ext_conv_sel ? conv_fall : int_tick;
    assign conv_now = conv_en_ff & conv_time & (~scanning | scan_gate);

    function [CNT_W-1:0] dec_sat;
        input [CNT_W-1:0] v;
        begin
            dec_sat = (v == {CNT_W{1'b0}}) ? v : v - ONE;
        end
    endfunction

    always @* begin
        nxt_state = state_ff;
        nxt_conv_en = conv_en_ff;
        nxt_count_run = count_run_ff;
        nxt_interval = sample_interval_counter;
        nxt_count = sample_count_counter;
        nxt_convert = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (start_acq) begin
                    nxt_count = sample_count_load;
                    nxt_interval = sample_interval_load;
                    if (!trig_ok) begin
                        nxt_state = S_RUN;
                        nxt_conv_en = ~ext_conv_sel;
                        nxt_count_run = 1'b1;
                    end else if (pre_sel) begin
                        nxt_state = S_RUN;
                        nxt_conv_en = ~ext_conv_sel;
                        nxt_count_run = 1'b0;
                    end else begin
                        nxt_state = S_ARMED;
                        nxt_conv_en = 1'b0;
                        nxt_count_run = 1'b1;
                    end
                end
            end
            S_ARMED: begin
                if (trig_rise) begin
                    nxt_state = S_RUN;
                    nxt_conv_en = ~ext_conv_sel;
                    nxt_interval = sample_interval_load;
                end
            end
            S_RUN: begin
                // External timing waits for a convert rise before enabling
                if (ext_conv_sel && !conv_en_ff && conv_rise)
                    nxt_conv_en = 1'b1;
                if (pre_sel && trig_ok && !count_run_ff && trig_rise)
                    nxt_count_run = 1'b1;
                if (conv_en_ff && !ext_conv_sel)
                    nxt_interval = int_tick ? sample_interval_load
                        : dec_sat(sample_interval_counter);
                if (conv_now) begin
                    nxt_convert = 1'b1;
                    if (count_run_ff)
                        nxt_count = dec_sat(sample_count_counter);
                end
                if (count_run_ff && (sample_count_counter == {CNT_W{1'b0}}
                    || (conv_now && sample_count_counter == ONE))) begin
                    nxt_state = S_DONE;
                    nxt_conv_en = 1'b0;
                end
            end
            S_DONE: begin
                nxt_conv_en = 1'b0;
            end
            default: begin
                nxt_state = S_IDLE;
                nxt_conv_en = 1'b0;
            end
        endcase
        if (stop_acq) begin
            nxt_state = S_IDLE;
            nxt_conv_en = 1'b0;
            nxt_count_run = 1'b0;
        end
    end

    // Scan interval timing and conversion gate
    always @* begin
        nxt_scan_cnt = scan_interval_counter;
        nxt_scan_tick = 1'b0;
        nxt_scan_pend = scan_pend_ff;
        nxt_scan_left = scan_left_ff;
        nxt_gate = scan_gate;
        if (scanning && !ext_scan_sel && state_ff == S_RUN) begin
            if (scan_interval_counter <= ONE) begin
                nxt_scan_cnt = scan_interval_load;
                nxt_scan_tick = 1'b1;
            end else begin
                nxt_scan_cnt = scan_interval_counter - ONE;
            end
        end else if (state_ff != S_RUN) begin
            nxt_scan_cnt = scan_interval_load;
        end
        if (scan_src)
            nxt_scan_pend = 1'b1;
        if (scan_pend_ff && (!ext_conv_sel || conv_rise)) begin
            nxt_gate = 1'b1;
            nxt_scan_pend = scan_src;
            nxt_scan_left = scan_length;
        end
        if (scan_gate && conv_now) begin
            nxt_scan_left = dec_sat(scan_left_ff);
            if (scan_left_ff <= ONE)
                nxt_gate = 1'b0;
        end
        if (!scanning || state_ff != S_RUN) begin
            nxt_gate = 1'b0;
            nxt_scan_pend = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            state_ff <= S_IDLE;
            conv_en_ff <= 1'b0;
            count_run_ff <= 1'b0;
            sample_interval_counter <= {CNT_W{1'b0}};
            sample_count_counter <= {CNT_W{1'b0}};
            scan_interval_counter <= {CNT_W{1'b0}};
            scan_left_ff <= {CNT_W{1'b0}};
            scan_tick_ff <= 1'b0;
            scan_pend_ff <= 1'b0;
            convert_pulse <= 1'b0;
            acq_active <= 1'b0;
            acq_done <= 1'b0;
            trigger_seen <= 1'b0;
            scan_gate <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            conv_en_ff <= nxt_conv_en;
            count_run_ff <= nxt_count_run;
            sample_interval_counter <= nxt_interval;
            sample_count_counter <= nxt_count;
            scan_interval_counter <= nxt_scan_cnt;
            scan_left_ff <= nxt_scan_left;
            scan_tick_ff <= nxt_scan_tick;
            scan_pend_ff <= nxt_scan_pend;
            convert_pulse <= nxt_convert;
            acq_active <= (nxt_state == S_RUN);
            acq_done <= (nxt_state == S_DONE);
            trigger_seen <= (nxt_state == S_RUN) & trig_ok & (post_sel
                | nxt_count_run);
            scan_gate <= nxt_gate;
        end
    end

    // DAC update path
    wire upd_active = ~upd_lvl;
    always @(posedge clk) begin
        if (srst) begin
            dac0_hold_ff <= `DAC_RESET;
            dac1_hold_ff <= `DAC_RESET;
            dac0_pend_ff <= 1'b0;
            dac1_pend_ff <= 1'b0;
            dac0_out <= `DAC_RESET;
            dac1_out <= `DAC_RESET;
            dac_output_update <= 1'b0;
            host_interrupt <= 1'b0;
        end else begin
            dac_output_update <= 1'b0;
            if (dac_write_strobe && !dac_sel) begin
                dac0_hold_ff <= dac_wdata;
                dac0_pend_ff <= 1'b1;
            end else if (delayed_update_mode && upd_active) begin
                dac0_pend_ff <= 1'b0;
            end
            if (dac_write_strobe && dac_sel) begin
                dac1_hold_ff <= dac_wdata;
                dac1_pend_ff <= 1'b1;
            end else if (delayed_update_mode && upd_active) begin
                dac1_pend_ff <= 1'b0;
            end
            if (!delayed_update_mode) begin
                if (dac_write_strobe) begin
                    dac_output_update <= 1'b1;
                    if (dac_sel)
                        dac1_out <= dac_wdata;
                    else
                        dac0_out <= dac_wdata;
                end
            end else if (upd_active) begin
                dac_output_update <= 1'b1;
                dac0_out <= dac0_hold_ff;
                dac1_out <= dac1_hold_ff;
            end
            if (int_enable && upd_rise)
                host_interrupt <= 1'b1;
            else if (int_clear || !int_enable)
                host_interrupt <= 1'b0;
        end
    end
endmodule // daq_trigger_timing_control

/* File: sim/ext_timing_source.sv */
// Model of the external timing equipment driving the block's timing lines
module ext_timing_source (
    // Clock
    input wire logic clk,
    // Timing lines toward the block
    output logic ext_convert_n,
    output logic ext_trigger,
    output logic scan_interval_line,
    output logic ext_dac_update_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // 50 ns of setup at 4 ns per cycle, rounded up with margin
    localparam int SETUP_CYC = 14;
    initial begin
        ext_convert_n = 1'b1;
        ext_trigger = 1'b0;
        scan_interval_line = 1'b0;
        ext_dac_update_n = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Each pulse is a fall then a rise, four cycles apart
    task automatic conv(input int n);
        repeat (n) begin
            @(posedge clk) ext_convert_n <= 1'b0;
            hold(4);
            ext_convert_n <= 1'b1;
            hold(4);
        end
    endtask
    task automatic trig_conv(input int n);
        @(posedge clk) ext_trigger <= 1'b1;
        hold(SETUP_CYC);
        conv(n);
        ext_trigger <= 1'b0;
    endtask
    task automatic scan_conv(input int n);
        @(posedge clk) scan_interval_line <= 1'b1;
        hold(SETUP_CYC);
        conv(n);
        scan_interval_line <= 1'b0;
    endtask
    task automatic upd(input int n);
        @(posedge clk) ext_dac_update_n <= 1'b0;
        hold(n);
        ext_dac_update_n <= 1'b1;
    endtask
endmodule // ext_timing_source

/* File: sim/daq_timing_asserts.sv */
// Concurrent checks on the acquisition trigger and timing block ports
module daq_timing_asserts #(
    parameter DAC_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Inputs watched
    input wire ext_dac_update_n,
    input wire stop_acq,
    input wire trigger_enable,
    input wire post_trigger_mode,
    input wire pre_trigger_mode,
    input wire ext_conv_sel,
    input wire scan_enable,
    input wire delayed_update_mode,
    input wire int_enable,
    input wire int_clear,
    input wire dac_write_strobe,
    input wire dac_sel,
    input wire [DAC_W-1:0] dac_wdata,
    // Outputs watched
    input wire convert_pulse,
    input wire acq_done,
    input wire trigger_seen,
    input wire scan_gate,
    input wire [DAC_W-1:0] dac0_out,
    input wire [DAC_W-1:0] dac1_out,
    input wire dac_output_update,
    input wire host_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence upd_rise_s;
        $rose(ext_dac_update_n) ##0 (int_enable && !int_clear)[*6];
    endsequence
    sequence upd_idle_s;
        (delayed_update_mode && ext_dac_update_n)[*5];
    endsequence
    sequence upd_fall_s;
        $fell(ext_dac_update_n) ##0 delayed_update_mode[*5];
    endsequence
    reset_zero_a: assert property ($fell(srst) |-> !acq_done &&
        !host_interrupt && dac0_out == 0 && dac1_out == 0)
        else $error("outputs not cleared by reset");
    done_holds_a: assert property (acq_done && !stop_acq |=> acq_done)
        else $error("done dropped without stop");
    irq_holds_a: assert property (host_interrupt && int_enable &&
        !int_clear |=> host_interrupt) else $error("interrupt lost");
    irq_mask_a: assert property (!int_enable |=> !host_interrupt)
        else $error("interrupt while disabled");
    irq_rise_a: assert property (upd_rise_s |-> host_interrupt)
        else $error("no interrupt after update rise");
    conv_single_a: assert property (convert_pulse && ext_conv_sel
        |=> !convert_pulse) else $error("convert pulse too long");
    trig_mode_a: assert property ($rose(trigger_seen) |->
        trigger_enable && (post_trigger_mode != pre_trigger_mode))
        else $error("trigger taken in no mode");
    scan_gate_a: assert property ($rose(scan_gate) |-> scan_enable)
        else $error("scan gate without scanning");
    dac_hold_a: assert property (upd_idle_s |->
        $stable(dac0_out) && $stable(dac1_out))
        else $error("delayed output moved without update");
    dac_immed_a: assert property (!delayed_update_mode &&
        dac_write_strobe && !dac_sel |=> dac0_out == $past(dac_wdata))
        else $error("immediate write not applied");
    upd_immed_a: assert property (!delayed_update_mode &&
        dac_write_strobe |=> dac_output_update)
        else $error("no update pulse on immediate write");
    upd_quiet_a: assert property (upd_idle_s |->
        !dac_output_update) else $error("update without low line");
    upd_load_a: assert property (upd_fall_s |->
        dac_output_update) else $error("low update line not applied");
    scan_conv_a: assert property (scan_enable &&
        convert_pulse |-> $past(scan_gate))
        else $error("conversion outside scan gate");
endmodule // daq_timing_asserts
bind daq_trigger_timing_control daq_timing_asserts #(.DAC_W(DAC_W)) chk_u (.*);

/* File: sim/tb_top.sv */
// Self-checking bench for the acquisition trigger and timing block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, start_acq, stop_acq, trigger_enable, post_trigger_mode;
    logic pre_trigger_mode, ext_conv_sel, scan_enable, ext_scan_sel;
    logic delayed_update_mode, int_enable, int_clear, dac_write_strobe;
    logic dac_sel, convert_pulse, acq_active, acq_done, trigger_seen;
    logic scan_gate, dac_output_update, host_interrupt, saw_gate = 1'b0;
    logic ext_convert_n, ext_trigger, scan_interval_line, ext_dac_update_n;
    logic [15:0] sample_interval_load, sample_count_load, scan_interval_load;
    logic [15:0] scan_length, d, cnt;
    logic [11:0] dac_wdata, dac0_out, dac1_out;
    logic [11:0] dv [2];
    int fails = 0, checked = 0, cyc = 0, nconv = 0, base;
    daq_trigger_timing_control dut_u (.*);
    ext_timing_source src_u (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (convert_pulse) nconv <= nconv + 1;
        if (scan_gate) saw_gate <= 1'b1;
        if (cyc == 4000) begin
            fails = fails + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse_start;
        start_acq <= 1'b1;
        tick(1);
        start_acq <= 1'b0;
    endtask
    task automatic stop;
        stop_acq <= 1'b1;
        tick(1);
        stop_acq <= 1'b0;
        tick(2);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 2000 && acq_done !== 1'b1; i++) tick(1);
    endtask
    // The first convert pulse after a trigger only enables
    function automatic int exp_conv(int pulses, int count);
        return (pulses - 1 < count) ? pulses - 1 : count;
    endfunction
    initial begin
        d = 16'($urandom(68602));
        srst = 1'b1;
        dv[0] = '0;
        dv[1] = '0;
        {start_acq, stop_acq, trigger_enable, post_trigger_mode} = '0;
        {pre_trigger_mode, ext_conv_sel, scan_enable, ext_scan_sel} = '0;
        {delayed_update_mode, int_enable, int_clear, dac_write_strobe} = '0;
        {dac_sel, dac_wdata, scan_length} = '0;
        sample_interval_load = 16'h0004;
        sample_count_load = 16'h0003;
        scan_interval_load = 16'h0020;
        tick(3);
        srst <= 1'b0;
        tick(4);
        chk(16'h0000, {acq_active, acq_done, trigger_seen, host_interrupt});
        cnt = 16'h0003;
        trigger_enable <= 1'b1;
        post_trigger_mode <= 1'b1;
        ext_conv_sel <= 1'b1;
        ext_scan_sel <= 1'b1;
        pulse_start();
        src_u.conv(2);
        chk(16'h0000, 16'(nconv));
        src_u.trig_conv(2);
        tick(8);
        chk(16'(exp_conv(2, cnt)), 16'(nconv));
        chk(16'h0003, {acq_active, trigger_seen});
        src_u.trig_conv(2);
        wait_done();
        chk(cnt, 16'(nconv));
        chk(16'h0001, acq_done);
        src_u.trig_conv(3);
        chk(cnt, 16'(nconv));
        stop();
        post_trigger_mode <= 1'b0;
        pre_trigger_mode <= 1'b1;
        ext_conv_sel <= 1'b0;
        sample_interval_load <= 16'h0002 + 16'($urandom % 4);
        sample_count_load <= 16'h0001 + 16'($urandom % 4);
        base = nconv;
        pulse_start();
        tick(60);
        chk(16'h0000, acq_done);
        chk(16'h0002, {acq_active, trigger_seen});
        chk(16'h0001, 16'(nconv > base));
        src_u.trig_conv(0);
        wait_done();
        chk(16'h0001, acq_done);
        stop();
        {trigger_enable, pre_trigger_mode} <= 2'b00;
        ext_conv_sel <= 1'b1;
        scan_enable <= 1'b1;
        scan_length <= 16'h0002;
        sample_count_load <= 16'h0100;
        pulse_start();
        src_u.scan_conv(3);
        chk(16'h0001, saw_gate);
        stop();
        ext_conv_sel <= 1'b0;
        ext_scan_sel <= 1'b0;
        sample_interval_load <= 16'h0002 + 16'($urandom % 2);
        scan_length <= 16'h0001 + 16'($urandom % 3);
        scan_interval_load <= 16'h0020 + 16'($urandom % 32);
        cnt = 16'h0004 + 16'($urandom % 4);
        sample_count_load <= cnt;
        base = nconv;
        pulse_start();
        wait_done();
        tick(2);
        chk(cnt, 16'(nconv - base));
        stop();
        scan_enable <= 1'b0;
        {trigger_enable, post_trigger_mode} <= 2'b11;
        base = nconv;
        pulse_start();
        tick(20);
        chk(16'h0000, 16'(nconv - base));
        src_u.trig_conv(0);
        wait_done();
        tick(2);
        chk(cnt, 16'(nconv - base));
        stop();
        repeat (8) begin
            d = 16'($urandom);
            delayed_update_mode <= d[15];
            int_enable <= d[14];
            dac_sel <= d[13];
            dac_wdata <= d[11:0];
            dac_write_strobe <= 1'b1;
            tick(1);
            dac_write_strobe <= 1'b0;
            tick(6);
            if (!d[15]) dv[d[13]] = d[11:0];
            chk(dv[d[13]], d[13] ? dac1_out : dac0_out);
            src_u.upd(3);
            tick(6);
            dv[d[13]] = d[11:0];
            chk(d[11:0], d[13] ? dac1_out : dac0_out);
            chk(d[14], host_interrupt);
            int_clear <= 1'b1;
            tick(1);
            int_clear <= 1'b0;
            tick(2);
            chk(16'h0000, host_interrupt);
        end
        wrap_up();
    end
endmodule // tb_top
